// ==== verilog/gpt_params.svh ====
// register offsets, field positions, reset values and timing counts
`ifndef GPT_PARAMS_SVH
`define GPT_PARAMS_SVH
`define GPT_OFF_CFG 12'h000
`define GPT_OFF_MODE 12'h004
`define GPT_OFF_CTL 12'h00C
`define GPT_OFF_IMR 12'h018
`define GPT_OFF_RIS 12'h01C
`define GPT_OFF_MIS 12'h020
`define GPT_OFF_ICR 12'h024
`define GPT_OFF_ILR 12'h028
`define GPT_OFF_MATCH 12'h030
`define GPT_OFF_PR 12'h038
`define GPT_OFF_TAR 12'h048
`define GPT_CFG_32 3'h0
`define GPT_CFG_RTC 3'h1
`define GPT_CFG_16 3'h4
`define GPT_MR_ONESHOT 2'h1
`define GPT_MR_PERIODIC 2'h2
`define GPT_MR_CAPTURE 2'h3
`define GPT_MODE_CMR 2
`define GPT_MODE_AMS 3
`define GPT_CTL_EN 0
`define GPT_CTL_EVT_LO 2
`define GPT_CTL_RTC_STALL_OVERRIDE 4
`define GPT_CTL_PWML 6
`define GPT_BIT_TO 0
`define GPT_BIT_CM 1
`define GPT_BIT_CE 2
`define GPT_BIT_RTC 3
`define GPT_EVT_POS 2'h0
`define GPT_EVT_NEG 2'h1
`define GPT_EVT_BOTH 2'h3
`define GPT_RST_LOAD 32'hFFFF_FFFF
`define GPT_RST_CNT16 16'hFFFF
`define GPT_RTC_DIV 15'h7FFF
`endif

// ==== verilog/gpt_pkg.sv ====
// types shared by the timer block
package gpt_pkg;
   typedef enum logic [2:0] {
      GPT_IDLE, GPT_PERIODIC, GPT_RTC, GPT_ECOUNT, GPT_ETIME, GPT_PWM
   } gpt_mode_e;
endpackage

// ==== verilog/gpt_timer.sv ====
// general-purpose timer: one-shot/periodic, rtc, edge count/time, pwm
//
// Implementation choices: the placing of the registers and the APB slave port.
`timescale 1ns/1ps
`include "gpt_params.svh"
module gpt_timer (
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // capture/compare pin
   input wire logic capture_compare_pin_in,
   output logic capture_compare_pin_out,
   output logic capture_compare_pin_oe_n
);
   import gpt_pkg::*;

   logic [2:0] width_config_q;
   logic [3:0] mode_q;
   logic [6:0] ctl_q;
   logic [3:0] imr_q;
   logic [3:0] ris_q;
   logic [31:0] ilr_q;
   logic [31:0] match_q;
   logic [7:0] pr_q;
   logic [31:0] cnt_q;
   logic [15:0] cap_q;
   logic [7:0] pre_q;
   logic [14:0] rdiv_q;
   logic pwm_q;
   logic [31:0] prdata_q;
   logic sync1_q, sync2_q, prev_q;
   logic ilr_wr, ctl_wr, icr_wr, apb_wr;
   logic rise, fall, edge_sel, en;
   logic [1:0] timer_mode_field;
   logic capture_type_sel, alternate_mode_sel, pwm_invert_bit;
   logic [1:0] evt;
   logic [3:0] ev_set;
   logic stop_en;
   gpt_mode_e mode;

   assign timer_mode_field = mode_q[1:0];
   assign capture_type_sel = mode_q[`GPT_MODE_CMR];
   assign alternate_mode_sel = mode_q[`GPT_MODE_AMS];
   assign pwm_invert_bit = ctl_q[`GPT_CTL_PWML];
   assign evt = ctl_q[`GPT_CTL_EVT_LO+1:`GPT_CTL_EVT_LO];
   assign en = ctl_q[`GPT_CTL_EN];

   // zero-wait apb: access phase completes in its first cycle
   assign apb_wr = psel & penable & pwrite;
   assign ilr_wr = apb_wr && paddr == `GPT_OFF_ILR;
   assign ctl_wr = apb_wr && paddr == `GPT_OFF_CTL;
   assign icr_wr = apb_wr && paddr == `GPT_OFF_ICR;

   // mode decode from configuration and mode fields
   always_comb begin
      mode = GPT_IDLE;
      if (width_config_q == `GPT_CFG_RTC) begin
         mode = GPT_RTC;
      end else if (timer_mode_field == `GPT_MR_CAPTURE) begin
         mode = capture_type_sel ? GPT_ETIME : GPT_ECOUNT;
      end else if (alternate_mode_sel && !capture_type_sel &&
                   timer_mode_field == `GPT_MR_PERIODIC) begin
         mode = GPT_PWM;
      end else if (timer_mode_field == `GPT_MR_ONESHOT ||
                   timer_mode_field == `GPT_MR_PERIODIC) begin
         mode = GPT_PERIODIC;
      end
   end

   // two-flop synchroniser, then a third stage for edge detection
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sync1_q <= 1'b0;
         sync2_q <= 1'b0;
         prev_q <= 1'b0;
      end else begin
         sync1_q <= capture_compare_pin_in;
         sync2_q <= sync1_q;
         prev_q <= sync2_q;
      end
   end
   assign rise = sync2_q & ~prev_q;
   assign fall = ~sync2_q & prev_q;

   // edge-time mode never takes both edges; "both" falls back to rising
   always_comb begin
      edge_sel = 1'b0;
      if (evt == `GPT_EVT_POS) begin
         edge_sel = rise;
      end else if (evt == `GPT_EVT_NEG) begin
         edge_sel = fall;
      end else if (evt == `GPT_EVT_BOTH) begin
         edge_sel = (mode == GPT_ETIME) ? rise : (rise | fall);
      end
   end

   // counter events that set status; one-shot timeout and edge-count match also end the run
   always_comb begin
      ev_set = 4'h0;
      stop_en = 1'b0;
      if (en) begin
         case (mode)
            GPT_PERIODIC: begin
               if ((width_config_q == `GPT_CFG_16 ? cnt_q[15:0] == 16'h0000
                    : cnt_q == 32'h0000_0000) && pre_q == 8'h00) begin
                  ev_set[`GPT_BIT_TO] = 1'b1;
                  stop_en = timer_mode_field == `GPT_MR_ONESHOT;
               end
            end
            GPT_RTC: begin
               if (rdiv_q == `GPT_RTC_DIV && edge_sel && cnt_q == match_q) begin
                  ev_set[`GPT_BIT_RTC] = 1'b1;
               end
            end
            GPT_ECOUNT: begin
               if (edge_sel && (cnt_q[15:0] - 16'h0001) == match_q[15:0]) begin
                  ev_set[`GPT_BIT_CM] = 1'b1;
                  stop_en = 1'b1;
               end
            end
            GPT_ETIME: begin
               ev_set[`GPT_BIT_CE] = edge_sel;
            end
            default: begin
               ev_set = 4'h0; // pwm raises nothing
            end
         endcase
      end
   end

   // configuration registers written over apb
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         width_config_q <= 3'h0;
         mode_q <= 4'h0;
         imr_q <= 4'h0;
         ilr_q <= `GPT_RST_LOAD;
         match_q <= `GPT_RST_LOAD;
         pr_q <= 8'h00;
      end else if (apb_wr) begin
         if (paddr == `GPT_OFF_CFG) begin
            width_config_q <= pwdata[2:0];
         end else if (paddr == `GPT_OFF_MODE) begin
            mode_q <= pwdata[3:0];
         end else if (paddr == `GPT_OFF_IMR) begin
            imr_q <= pwdata[3:0];
         end else if (paddr == `GPT_OFF_ILR) begin
            ilr_q <= pwdata;
         end else if (paddr == `GPT_OFF_MATCH) begin
            match_q <= pwdata;
         end else if (paddr == `GPT_OFF_PR) begin
            pr_q <= pwdata[7:0];
         end
      end
   end

   // control: hardware clear of enable wins over a same-cycle write
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctl_q <= 7'h00;
      end else if (stop_en) begin
         ctl_q[`GPT_CTL_EN] <= 1'b0;
      end else if (ctl_wr) begin
         ctl_q <= pwdata[6:0];
      end
   end

   // raw status: set wins over clear-by-one
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ris_q <= 4'h0;
      end else begin
         ris_q <= (ris_q & ~(icr_wr ? pwdata[3:0] : 4'h0))
                  | ev_set;
      end
   end

   // main counter with prescale and rtc 1 Hz divider
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt_q <= `GPT_RST_LOAD;
         pre_q <= 8'h00;
         rdiv_q <= 15'h0000;
      end else if (ilr_wr && mode != GPT_RTC) begin
         cnt_q <= pwdata; // new load takes effect next cycle
         pre_q <= pr_q;
      end else if (en) begin
         case (mode)
            GPT_PERIODIC: begin
               if (pre_q != 8'h00) begin
                  pre_q <= pre_q - 8'h01; // prescale only here
               end else if (ev_set[`GPT_BIT_TO]) begin
                  cnt_q <= ilr_q;
                  pre_q <= pr_q;
               end else begin
                  pre_q <= pr_q;
                  cnt_q <= cnt_q - 32'h0000_0001;
               end
            end
            GPT_RTC: begin
               if (edge_sel) begin
                  rdiv_q <= rdiv_q + 15'h0001;
                  if (rdiv_q == `GPT_RTC_DIV) begin
                     cnt_q <= ev_set[`GPT_BIT_RTC] ? 32'h0000_0000
                              : cnt_q + 32'h0000_0001;
                  end
               end
            end
            GPT_ECOUNT: begin
               if (stop_en) begin
                  cnt_q <= ilr_q;
               end else if (edge_sel) begin
                  cnt_q <= cnt_q - 32'h0000_0001;
               end
            end
            GPT_ETIME, GPT_PWM: begin
               if (cnt_q[15:0] == 16'h0000) begin
                  cnt_q <= ilr_q;
               end else begin
                  cnt_q <= {16'h0000, cnt_q[15:0] - 16'h0001};
               end
            end
            default: begin
               cnt_q <= cnt_q;
            end
         endcase
      end else if (mode == GPT_RTC) begin
         cnt_q <= 32'h0000_0001; // rtc starts counting from one
         rdiv_q <= 15'h0000;
      end
   end

   // capture register holds until the next selected edge
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cap_q <= `GPT_RST_CNT16;
      end else if (ev_set[`GPT_BIT_CE]) begin
         cap_q <= cnt_q[15:0];
      end
   end

   // pwm level: set at start value, clear at match
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pwm_q <= 1'b0;
      end else if (en && mode == GPT_PWM) begin
         if (cnt_q[15:0] == ilr_q[15:0]) begin
            pwm_q <= 1'b1;
         end else if (cnt_q[15:0] == match_q[15:0]) begin
            pwm_q <= 1'b0;
         end
      end else begin
         pwm_q <= 1'b0;
      end
   end

   // pin drive: output only in pwm mode, invert applied at the flop
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         capture_compare_pin_out <= 1'b0;
         capture_compare_pin_oe_n <= 1'b1;
      end else begin
         capture_compare_pin_out <= pwm_q ^ pwm_invert_bit;
         capture_compare_pin_oe_n <= !(mode == GPT_PWM);
      end
   end

   // read mux; unmapped addresses read zero without error
   always_comb begin
      prdata_q = 32'h0000_0000;
      if (paddr == `GPT_OFF_CFG) begin
         prdata_q = {29'h0000_0000, width_config_q};
      end else if (paddr == `GPT_OFF_MODE) begin
         prdata_q = {28'h000_0000, mode_q};
      end else if (paddr == `GPT_OFF_CTL) begin
         prdata_q = {25'h000_0000, ctl_q};
      end else if (paddr == `GPT_OFF_IMR) begin
         prdata_q = {28'h000_0000, imr_q};
      end else if (paddr == `GPT_OFF_RIS) begin
         prdata_q = {28'h000_0000, ris_q};
      end else if (paddr == `GPT_OFF_MIS) begin
         prdata_q = {28'h000_0000, ris_q & imr_q};
      end else if (paddr == `GPT_OFF_ILR) begin
         prdata_q = ilr_q;
      end else if (paddr == `GPT_OFF_MATCH) begin
         prdata_q = match_q;
      end else if (paddr == `GPT_OFF_PR) begin
         prdata_q = {24'h00_0000, pr_q};
      end else if (paddr == `GPT_OFF_TAR) begin
         prdata_q = (mode == GPT_ETIME) ? {16'h0000, cap_q} : cnt_q;
      end
   end

   // registered read data; pready/pslverr flops
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h0000_0000;
         pready <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         prdata <= (psel & ~penable & ~pwrite) ? prdata_q : prdata;
         pready <= psel & ~penable;
         pslverr <= 1'b0;
      end
   end

   // assertions
   a_stop_clears_en: assert property (@(posedge pclk) disable iff (!presetn)
      stop_en |=> !en) else $error("enable not cleared at stop");
   a_pwm_no_flags: assert property (@(posedge pclk) disable iff (!presetn)
      mode == GPT_PWM |-> ev_set == 4'h0)
      else $error("pwm set flag");
   a_flag_set_wins: assert property (@(posedge pclk) disable iff (!presetn)
      ev_set[`GPT_BIT_CE] |=> ris_q[`GPT_BIT_CE])
      else $error("capture flag lost");
   a_capture_value: assert property (@(posedge pclk) disable iff (!presetn)
      ev_set[`GPT_BIT_CE] |=> cap_q == $past(cnt_q[15:0]))
      else $error("capture wrong");
   a_capture_hold: assert property (@(posedge pclk) disable iff (!presetn)
      !ev_set[`GPT_BIT_CE] |=> $stable(cap_q))
      else $error("capture changed");
   a_ecount_dec: assert property (@(posedge pclk) disable iff (!presetn)
      en && mode == GPT_ECOUNT && edge_sel && !stop_en && !ilr_wr
      |=> cnt_q == $past(cnt_q) - 32'h0000_0001)
      else $error("edge not counted");
   a_ecount_idle: assert property (@(posedge pclk) disable iff (!presetn)
      !en && mode == GPT_ECOUNT && !ilr_wr |=> $stable(cnt_q))
      else $error("counted while off");
   a_edge_sync: assert property (@(posedge pclk) disable iff (!presetn)
      rise |-> $past(capture_compare_pin_in, 2) &&
      !$past(capture_compare_pin_in, 3))
      else $error("edge misdetected");
endmodule // gpt_timer

// ==== verif/gpt_pin_model.sv ====
// pin-side partner: edge source for capture, duty monitor for pwm
`timescale 1ns/1ps
module gpt_pin_model (
   // clock
   input wire logic pclk,
   // split capture/compare pin of the design
   input wire logic pin_out,
   input wire logic pin_oe_n,
   output logic pin_in
);
   logic level = 1'b0;

   // wire level: the design wins while it drives the pin
   assign pin_in = (pin_oe_n === 1'b0) ? pin_out : level;

   // each new level is held well past two clocks so no edge is lost
   task automatic toggle(input int n, input int hold);
      repeat (n) begin
         @(posedge pclk);
         level <= ~level;
         repeat ((hold < 2) ? 2 : hold) @(posedge pclk);
      end
   endtask

   // counts clocks where the design drives the pin high
   task automatic measure(input int n, output int hi);
      hi = 0;
      repeat (n) begin
         @(posedge pclk);
         if (pin_oe_n === 1'b0 && pin_in === 1'b1) hi++;
      end
   endtask
endmodule // gpt_pin_model

// ==== verif/tb_top.sv ====
// self-checking bench for the general-purpose timer
`timescale 1ns/1ps
`include "gpt_params.svh"
module tb_top;
   import gpt_pkg::*;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0000_0000;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   logic pin_in;
   logic pin_out;
   logic pin_oe_n;
   logic [31:0] rd;
   logic [31:0] tcap;
   int hi;
   int failures = 0;
   int checked = 0;
   // reset table: address and expected value
   logic [11:0] ra [7] = '{`GPT_OFF_CFG, `GPT_OFF_CTL, `GPT_OFF_RIS,
      `GPT_OFF_ILR, `GPT_OFF_MATCH, `GPT_OFF_TAR, 12'h0FC};
   logic [31:0] re [7] = '{32'h0, 32'h0, 32'h0, 32'hFFFF_FFFF,
      32'hFFFF_FFFF, 32'hFFFF_FFFF, 32'h0};
   // edge count cases: rising, falling, both
   logic [31:0] ce [3] = '{32'h0, 32'h4, 32'hC};
   logic [31:0] cm [3] = '{32'h0, 32'h2, 32'h0};
   int t1 [3] = '{4, 4, 2};
   int t2 [3] = '{1, 1, 3};

   // 10 mhz system clock
   always #50 pclk = ~pclk;

   gpt_timer i_dut (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr),
      .capture_compare_pin_in(pin_in),
      .capture_compare_pin_out(pin_out),
      .capture_compare_pin_oe_n(pin_oe_n)
   );

   gpt_pin_model i_pin (
      .pclk(pclk), .pin_out(pin_out), .pin_oe_n(pin_oe_n), .pin_in(pin_in)
   );

   task automatic end_sim;
      if (failures == 0 && checked > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp,
         input string what);
      checked++;
      if (got !== exp) begin
         failures++;
         $display("wrong value at %0t: %s got %h expected %h",
            $time, what, got, exp);
      end
   endtask

   // one apb transfer; request held until pready is sampled high
   task automatic apb(input logic w, input logic [11:0] a,
         input logic [31:0] d, output logic [31:0] r);
      int n;
      n = 0;
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 16);
      if (pready !== 1'b1) begin
         failures++;
         $display("wrong value at %0t: no pready", $time);
         end_sim();
      end
      r = prdata;
      chk({31'h0, pslverr}, 32'h0, "slave error");
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      apb(1'b1, a, d, rd);
   endtask

   task automatic rd_chk(input logic [11:0] a, input logic [31:0] m,
         input logic [31:0] e);
      apb(1'b0, a, 32'h0, rd);
      chk(rd & m, e, $sformatf("read %h", a));
   endtask

   // hang guard, far above the test's run length
   initial begin
      repeat (100000) @(posedge pclk);
      failures++;
      $display("wrong value at %0t: run too long", $time);
      end_sim();
   end

   initial begin
      repeat (12) @(posedge pclk);
      presetn <= 1'b1;
      // reset values, then read-only and unmapped writes
      foreach (ra[i]) rd_chk(ra[i], 32'hFFFF_FFFF, re[i]);
      wr(`GPT_OFF_RIS, 32'hF);
      wr(12'h0FC, 32'hFFFF_FFFF);
      rd_chk(`GPT_OFF_RIS, 32'hFFFF_FFFF, 32'h0);
      rd_chk(12'h0FC, 32'hFFFF_FFFF, 32'h0);
      // edge count: midway no match, then match, reload and stop
      for (int i = 0; i < 3; i++) begin
         wr(`GPT_OFF_CFG, 32'h4);
         wr(`GPT_OFF_MODE, 32'h3);
         wr(`GPT_OFF_CTL, ce[i]);
         wr(`GPT_OFF_PR, 32'hFF);
         wr(`GPT_OFF_ILR, 32'h5);
         wr(`GPT_OFF_MATCH, 32'h2);
         wr(`GPT_OFF_IMR, cm[i]);
         wr(`GPT_OFF_CTL, ce[i] | 32'h1);
         i_pin.toggle(t1[i], 3);
         repeat (6) @(posedge pclk);
         rd_chk(`GPT_OFF_RIS, 32'h2, 32'h0);
         rd_chk(`GPT_OFF_TAR, 32'hFFFF, 32'h3);
         i_pin.toggle(t2[i], 3);
         repeat (6) @(posedge pclk);
         rd_chk(`GPT_OFF_RIS, 32'h2, 32'h2);
         rd_chk(`GPT_OFF_MIS, 32'h2, cm[i]);
         rd_chk(`GPT_OFF_CTL, 32'hFF, ce[i]);
         rd_chk(`GPT_OFF_TAR, 32'hFFFF, 32'h5);
         wr(`GPT_OFF_ICR, 32'h2);
         rd_chk(`GPT_OFF_RIS, 32'hF, 32'h0);
      end
      // edge time on rising edges, counter wraps between captures
      wr(`GPT_OFF_MODE, 32'h7);
      wr(`GPT_OFF_CTL, 32'h0);
      wr(`GPT_OFF_ILR, 32'h40);
      wr(`GPT_OFF_IMR, 32'h4);
      wr(`GPT_OFF_CTL, 32'h1);
      for (int k = 0; k < 3; k++) begin
         repeat (100) @(posedge pclk);
         i_pin.toggle(1, 3);
         repeat (6) @(posedge pclk);
         rd_chk(`GPT_OFF_RIS, 32'h4, 32'h0);
         i_pin.toggle(1, 3);
         repeat (6) @(posedge pclk);
         rd_chk(`GPT_OFF_MIS, 32'h4, 32'h4);
         apb(1'b0, `GPT_OFF_TAR, 32'h0, tcap);
         chk({31'h0, tcap <= 32'h40}, 32'h1, "capture range");
         repeat (20) @(posedge pclk);
         rd_chk(`GPT_OFF_TAR, 32'hFFFF_FFFF, tcap);
         wr(`GPT_OFF_ICR, 32'h4);
      end
      // pwm: period of ten clocks, six high, four when inverted, prescale ignored
      wr(`GPT_OFF_CTL, 32'h0);
      wr(`GPT_OFF_MODE, 32'hA);
      wr(`GPT_OFF_ILR, 32'h9);
      wr(`GPT_OFF_MATCH, 32'h3);
      wr(`GPT_OFF_IMR, 32'hF);
      for (int p = 0; p < 2; p++) begin
         wr(`GPT_OFF_CTL, (p == 1) ? 32'h41 : 32'h1);
         repeat (20) @(posedge pclk);
         i_pin.measure(100, hi);
         chk(32'(hi), (p == 1) ? 32'd40 : 32'd60, "pwm high");
         wr(`GPT_OFF_CTL, 32'h0);
      end
      rd_chk(`GPT_OFF_RIS, 32'hF, 32'h0);
      // one-shot clears enable, periodic keeps it, in both widths
      for (int j = 0; j < 4; j++) begin
         wr(`GPT_OFF_CTL, 32'h0);
         wr(`GPT_OFF_CFG, (j > 1) ? 32'h4 : 32'h0);
         wr(`GPT_OFF_MODE, ((j & 1) == 1) ? 32'h2 : 32'h1);
         wr(`GPT_OFF_PR, 32'h0);
         wr(`GPT_OFF_ILR, 32'd20);
         wr(`GPT_OFF_IMR, 32'h1);
         wr(`GPT_OFF_CTL, 32'h1);
         repeat (60) @(posedge pclk);
         rd_chk(`GPT_OFF_MIS, 32'h1, 32'h1);
         rd_chk(`GPT_OFF_CTL, 32'h1, 32'(j & 1));
         wr(`GPT_OFF_CTL, 32'h0);
         wr(`GPT_OFF_ICR, 32'h1);
         rd_chk(`GPT_OFF_RIS, 32'h1, 32'h0);
      end
      // rtc: starts at one; a few input clocks stay inside the divider
      wr(`GPT_OFF_CFG, 32'h1);
      rd_chk(`GPT_OFF_TAR, 32'hFFFF_FFFF, 32'h1);
      wr(`GPT_OFF_CTL, 32'h1);
      i_pin.toggle(8, 3);
      rd_chk(`GPT_OFF_TAR, 32'hFFFF_FFFF, 32'h1);
      rd_chk(`GPT_OFF_RIS, 32'h8, 32'h0);
      wr(`GPT_OFF_CTL, 32'h0);
      end_sim();
   end
endmodule // tb_top
